// File: logic/cst_timer_map.svh
// Constants for the charger safety timer block
// Overview of operation
// [R1] No adapter and no bus input: charger off
// [R2] Precharge timer runs during preconditioning
// [R3] Precharge timeout is one tenth of fast
// [R4] Suspend pauses both timers without reset
// [R5] Precharge expiry below threshold: fault, off
// [R6] Floating timing pin selects internal timebase
// [R7] Fast timer starts when preconditioning ends
// [R8] Fast expiry without termination: fault, off
// [R9] Floating pin or termination off holds fast
// [R10] Fault above recharge: wait drop, restart
// [R11] Fault below recharge: pull-up on while below
// [R12] Rising above recharge drops pull-up, waits
// [R13] Toggled enables or power cycle reset timers
// [R14] Undervoltage lockout resets timers and faults
// [R15] Loop activity slows the timer clock
// [R16] Depleted battery: slow precharge on loops
// [R17] Fast slowed only with loop and below recharge
// [R18] Stretch follows reference over measured ratio
// [R19] Stretched period at most twice nominal
// [R20] Added time capped at twice the timeout
// [R21] Status valid only with input power present
// [R22] Termination off after done restarts charge
// [R23] Prescaled counters with saturating added time
`ifndef CST_TIMER_MAP_SVH
`define CST_TIMER_MAP_SVH
`define CST_CLK_PERIOD_NS 4
`define CST_TICK_EXT_NS 1000
`define CST_TICK_INT_NS 500
`define CST_TICK_EXT_CYC ((`CST_TICK_EXT_NS + `CST_CLK_PERIOD_NS - 1) / `CST_CLK_PERIOD_NS)
`define CST_TICK_INT_CYC ((`CST_TICK_INT_NS + `CST_CLK_PERIOD_NS - 1) / `CST_CLK_PERIOD_NS)
`define CST_FAST_TICKS 10000
`define CST_PRE_DIV 10
`define CST_RATIO_ONE 8'h80
`endif

// File: logic/cst_pkg.sv
// Types for the charger safety timer block
`default_nettype none
package cst_pkg;
	typedef enum {CST_OFF, CST_PRE, CST_FAST, CST_DONE, CST_FAULT_WAIT, CST_FAULT_PULL}
		cst_state_t;
	typedef struct packed {
		logic ac_present;
		logic usb_present;
		logic uvlo;
		logic bat_above_pre;
		logic bat_above_rch;
		logic bat_above_depleted;
		logic term_detect;
		logic temp_fault;
		logic thermal_active;
		logic ppath_active;
		logic tmr_floating;
	} cst_sense_t;
	typedef struct packed {
		logic charger_enable;
		logic charge_on;
		logic term_off;
	} cst_ctrl_t;
	typedef struct packed {
		logic charger_on;
		logic precharge;
		logic fast_charge;
		logic done;
		logic timer_fault;
		logic pullup_on;
		logic slowed;
	} cst_status_t;
endpackage
`default_nettype wire

// File: logic/cst_timer.sv
// Charger safety timers with fault recovery and dynamic slowdown
`timescale 1ns/100ps
`default_nettype none
`include "cst_timer_map.svh"
module cst_timer
	import cst_pkg::*;
#(
	parameter int TICK_EXT_CYC = `CST_TICK_EXT_CYC,
	parameter int TICK_INT_CYC = `CST_TICK_INT_CYC,
	parameter int FAST_TICKS = `CST_FAST_TICKS,
	parameter int PRE_DIV = `CST_PRE_DIV
)
(
	input wire logic core_clk,
	input wire logic reset_n,
	input wire cst_sense_t sense,
	input wire cst_ctrl_t ctrl,
	input wire logic [7:0] iset_ratio,
	output var cst_status_t status
);
	// Precharge limit is a tenth of the fast limit, rounded down
	localparam int PRE_TICKS = FAST_TICKS / PRE_DIV;
	localparam int TW = $clog2(3 * FAST_TICKS + 2);
	localparam int PW = $clog2(TICK_EXT_CYC * 2 + TICK_INT_CYC * 2 + 2);

	// Timeouts below the divider would give a zero precharge limit
	if (PRE_DIV < 1 || FAST_TICKS < PRE_DIV)
	begin : g_bad_ticks
		$error("cst_timer: bad timeout parameters");
	end
	// The stretch product is 16 bits wide, so the base tick must stay small
	if (TICK_EXT_CYC < 1 || TICK_INT_CYC < 1 || TICK_EXT_CYC > 256 || TICK_INT_CYC > 256)
	begin : g_bad_base
		$error("cst_timer: bad timebase parameters");
	end

	cst_state_t state;
	cst_state_t next_state;
	cst_state_t fault_next;
	cst_state_t start_next;

	logic [PW-1:0] pre_cnt;
	logic [PW-1:0] next_pre_cnt;
	logic [TW-1:0] tmr_cnt;
	logic [TW-1:0] next_tmr_cnt;
	logic [TW-1:0] add_cnt;
	logic [TW-1:0] next_add_cnt;
	cst_ctrl_t ctrl_q;
	logic power_q;
	cst_status_t next_status;

	// Input qualification
	wire logic power_ok = sense.ac_present | sense.usb_present;
	wire logic input_off = !power_ok; // R1
	wire logic enabled = ctrl.charger_enable;
	wire logic en_rise = ctrl.charger_enable & !ctrl_q.charger_enable;
	wire logic on_rise = ctrl.charge_on & !ctrl_q.charge_on;
	wire logic power_rise = power_ok & !power_q;
	// A toggled enable bit or returning power restarts a cycle
	wire logic restart = en_rise | on_rise | power_rise; // R13
	// Charge-on low only suspends, so it must not clear the timers
	wire logic kill = sense.uvlo | input_off | !enabled; // R14
	wire logic suspend = !ctrl.charge_on | sense.temp_fault; // R4

	// State decode
	wire logic in_off = state == CST_OFF;
	wire logic in_pre = state == CST_PRE;
	wire logic in_fast = state == CST_FAST;
	wire logic in_done = state == CST_DONE;
	wire logic in_wait = state == CST_FAULT_WAIT;
	wire logic in_pull = state == CST_FAULT_PULL;
	wire logic in_timed = in_pre | in_fast;

	// Slowdown requests
	wire logic loop_on = sense.thermal_active | sense.ppath_active; // R15
	wire logic fast_hold = sense.tmr_floating | ctrl.term_off; // R9
	wire logic fast_held = in_fast & fast_hold;
	wire logic slow_pre = loop_on & in_pre & !sense.bat_above_depleted; // R16
	wire logic slow_fast = loop_on & in_fast & !sense.bat_above_rch; // R17
	wire logic slow_req = slow_pre | slow_fast;

	// Floating pin uses the internal resistor timebase
	wire logic [PW-1:0] base_int = PW'(TICK_INT_CYC);
	wire logic [PW-1:0] base_ext = PW'(TICK_EXT_CYC);
	wire logic [PW-1:0] base = sense.tmr_floating ? base_int : base_ext; // R6
	wire logic [15:0] base_w = 16'(base);
	wire logic [15:0] ratio_w = 16'(iset_ratio);
	wire logic [15:0] product = base_w * ratio_w;
	// Ratio 8'h80 is unity, so the product carries seven fraction bits
	wire logic [15:0] scaled = product >> 7; // R18
	wire logic [PW:0] period1 = {1'b0, base};
	wire logic [PW:0] period2 = {base, 1'b0};
	wire logic [16:0] scaled_w = {1'b0, scaled};
	wire logic [16:0] period2_w = 17'(period2);
	wire logic [16:0] period1_w = 17'(period1);
	wire logic over_cap = scaled_w > period2_w; // R19
	wire logic under_one = scaled_w < period1_w;
	wire logic [PW:0] scaled_n = (PW+1)'(scaled);
	wire logic [PW:0] stretch_sel = over_cap ? period2 : (under_one ? period1 : scaled_n);
	wire logic [PW:0] stretched = slow_req ? stretch_sel : period1; // R18
	wire logic [PW:0] pre_next_w = {1'b0, pre_cnt} + (PW+1)'(1);
	wire logic tick = pre_next_w >= stretched;

	// Timeout limits and tick routing
	wire logic [TW-1:0] pre_limit = TW'(PRE_TICKS);
	wire logic [TW-1:0] fast_limit = TW'(FAST_TICKS);
	wire logic [TW-1:0] limit = in_pre ? pre_limit : fast_limit; // R3
	wire logic [TW:0] cap = {limit, 1'b0};
	wire logic add_full = {1'b0, add_cnt} >= cap; // R20
	wire logic counting = tick & in_timed & !suspend & !fast_held; // R4
	// A slowed tick goes to the added time until the cap is reached
	wire logic to_add = counting & slow_req & !add_full; // R20
	wire logic to_tmr = counting & !to_add; // R2
	// At or above, so a count can never wrap past its limit
	wire logic expired = tmr_cnt >= limit;
	wire logic phase_change = next_state != state;
	wire logic clear_cnt = phase_change | in_off;

	// Timeout faults pick their recovery path from the recharge threshold
	assign fault_next = sense.bat_above_rch ? CST_FAULT_WAIT : CST_FAULT_PULL; // R11
	assign start_next = sense.bat_above_pre ? CST_FAST : CST_PRE;
	wire logic term_seen = sense.term_detect & !ctrl.term_off;
	wire logic fast_expired = expired & !fast_hold; // R8
	wire logic done_leave = !sense.bat_above_rch | ctrl.term_off; // R22
	wire logic wait_leave = !sense.bat_above_rch; // R10
	wire logic pull_leave = sense.bat_above_rch; // R12
	wire logic stop_now = kill | restart;

	// Status other than slowed follows the state being entered
	wire logic go_pre = next_state == CST_PRE;
	wire logic go_fast = next_state == CST_FAST;
	wire logic go_done = next_state == CST_DONE;
	wire logic go_wait = next_state == CST_FAULT_WAIT;
	wire logic go_pull = next_state == CST_FAULT_PULL;
	wire logic go_on = go_pre | go_fast;
	wire logic go_fault = go_wait | go_pull;
	assign next_status = '{
		charger_on: go_on,
		precharge: go_pre,
		fast_charge: go_fast,
		done: go_done,
		timer_fault: go_fault,
		pullup_on: go_pull,
		slowed: slow_req
	};

	// Suspend freezes the prescaler too, so a resumed tick is not cut short
	always_comb
	begin
		next_pre_cnt = pre_cnt;
		next_tmr_cnt = tmr_cnt;
		next_add_cnt = add_cnt;
		if (clear_cnt)
		begin
			next_pre_cnt = '0;
			next_tmr_cnt = '0;
			next_add_cnt = '0;
		end
		else if (fast_held)
		begin
			// Held in reset, not merely paused
			next_pre_cnt = '0; // R9
			next_tmr_cnt = '0; // R9
		end
		else if (in_timed && !suspend)
		begin
			next_pre_cnt = tick ? '0 : pre_cnt + PW'(1); // R23
			if (to_add)
				next_add_cnt = add_cnt + TW'(1); // R20
			if (to_tmr)
				next_tmr_cnt = tmr_cnt + TW'(1); // R2
		end
	end

	// Kill and restart override every branch below
	always_comb
	begin
		next_state = state;
		unique case (state)
			CST_OFF:
			begin
				if (!kill)
					next_state = start_next; // R2
			end
			CST_PRE:
			begin
				if (sense.bat_above_pre)
					next_state = CST_FAST; // R7
				else if (expired)
					next_state = fault_next; // R5
			end
			CST_FAST:
			begin
				if (term_seen)
					next_state = CST_DONE;
				else if (fast_expired)
					next_state = fault_next; // R8
			end
			CST_DONE:
			begin
				if (done_leave)
					next_state = CST_OFF; // R22
			end
			CST_FAULT_WAIT:
			begin
				if (wait_leave)
					next_state = CST_OFF; // R10
			end
			CST_FAULT_PULL:
			begin
				if (pull_leave)
					next_state = CST_FAULT_WAIT; // R12
			end
		endcase
		if (stop_now)
			next_state = CST_OFF; // R13
	end

	// Charger state
	always_ff @(posedge core_clk)
	begin
		if (!reset_n)
		begin
			state <= CST_OFF;
		end
		else
		begin
			state <= next_state;
		end
	end

	// Prescaler
	always_ff @(posedge core_clk)
	begin
		if (!reset_n)
		begin
			pre_cnt <= '0;
		end
		else
		begin
			pre_cnt <= next_pre_cnt;
		end
	end

	// Safety timer count
	always_ff @(posedge core_clk)
	begin
		if (!reset_n)
		begin
			tmr_cnt <= '0;
		end
		else
		begin
			tmr_cnt <= next_tmr_cnt;
		end
	end

	// Added time while a loop slows the charge
	always_ff @(posedge core_clk)
	begin
		if (!reset_n)
		begin
			add_cnt <= '0;
		end
		else
		begin
			add_cnt <= next_add_cnt;
		end
	end

	// Status is only meaningful to software while input power exists
	always_ff @(posedge core_clk)
	begin
		if (!reset_n)
		begin
			status <= '0;
		end
		else
		begin
			status <= next_status; // R11
		end
	end

	// Edge detectors follow the pins in reset too, so no false edge follows it
	always_ff @(posedge core_clk)
	begin
		ctrl_q <= ctrl;
	end

	always_ff @(posedge core_clk)
	begin
		power_q <= power_ok;
	end
endmodule // cst_timer
`default_nettype wire

// File: tb/cst_props.sv
// Port assertions for the charger safety timers
`timescale 1ns/100ps
`default_nettype none
module cst_props import cst_pkg::*;
#(parameter int TICK_EXT_CYC = 2, TICK_INT_CYC = 1, FAST_TICKS = 20, PRE_DIV = 10)
(
	input wire logic core_clk,
	input wire logic reset_n,
	input wire cst_sense_t sense,
	input wire cst_ctrl_t ctrl,
	input wire logic [7:0] iset_ratio,
	input wire cst_status_t status
);
	default clocking @(posedge core_clk); endclocking
	default disable iff (!reset_n);
	wire logic pwr_in = sense.ac_present || sense.usb_present;
	// Internal timebase excluded: its timeout may be shorter
	sequence pre_start;
		$rose(status.precharge) && !sense.tmr_floating;
	endsequence
	chk_off_idle: assert property (!pwr_in |=> !status.charger_on)
		else $error("on without power");
	chk_pre_early: assert property (pre_start |=> (!status.timer_fault) [*2])
		else $error("early timeout");
	chk_fault_off: assert property (status.timer_fault |-> !status.charger_on)
		else $error("on in fault");
	chk_fast_entry: assert property ($rose(status.fast_charge) |-> $past(sense.bat_above_pre))
		else $error("fast from low battery");
	chk_fast_held: assert property (status.fast_charge && ctrl.term_off |=> !status.timer_fault)
		else $error("held timer expired");
	chk_pullup_drop: assert property (status.pullup_on && sense.bat_above_rch |=> !status.pullup_on)
		else $error("pull-up stuck");
	chk_uvlo_clear: assert property (sense.uvlo |=> !status.timer_fault && !status.charger_on)
		else $error("fault kept in lockout");
	chk_slow_cause: assert property (status.slowed |-> $past(sense.thermal_active || sense.ppath_active))
		else $error("slowed without loop");
endmodule // cst_props
bind cst_timer cst_props #(.TICK_EXT_CYC(TICK_EXT_CYC), .TICK_INT_CYC(TICK_INT_CYC),
	.FAST_TICKS(FAST_TICKS), .PRE_DIV(PRE_DIV)) u_props (.core_clk(core_clk),
	.reset_n(reset_n), .sense(sense), .ctrl(ctrl), .iset_ratio(iset_ratio), .status(status));
`default_nettype wire

// File: tb/cst_batt_model.sv
// Battery model on the charger's far side
`timescale 1ns/100ps
`default_nettype none
module cst_batt_model
(
	input wire logic core_clk,
	input wire logic charging,
	input wire logic [7:0] target,
	output logic [3:0] bat
);
	logic [7:0] level = 8'h00;
	// One step a cycle, so thresholds are crossed slowly
	always @(posedge core_clk)
		level <= level + 8'(level < target) - 8'(level > target);
	assign bat = {level > 8'h30, level > 8'hc0, level > 8'h10, charging && level == 8'hff};
endmodule // cst_batt_model
`default_nettype wire

// File: tb/tb.sv
// Self-checking bench for the charger safety timers
`timescale 1ns/100ps
`default_nettype none
`define CHK(nm, e, a) begin n_compared++; if ((e) !== (a)) begin fails++; \
	$display("MISMATCH %s exp %h got %h", nm, e, a); end end
module tb;
	import cst_pkg::*;
	logic core_clk = 0, reset_n = 0;
	cst_sense_t sd = '0, sense;
	cst_ctrl_t ctrl = 3'h6;
	cst_status_t status;
	logic [7:0] iset_ratio = 8'h80, target = 8'h00;
	logic [13:0] q[$], e;
	logic [3:0] bat;
	int fails = 0, n_compared = 0, seed = 32'h1de8, n;
	assign sense = {sd[10:8], bat, sd[3:0]};
	always #2 core_clk = ~core_clk;
	cst_timer #(.TICK_EXT_CYC(2), .TICK_INT_CYC(1), .FAST_TICKS(20), .PRE_DIV(10)) DUT (.core_clk(core_clk),
		.reset_n(reset_n), .sense(sense), .ctrl(ctrl), .iset_ratio(iset_ratio), .status(status));
	cst_batt_model model (.core_clk(core_clk), .charging(status.charger_on), .target(target),
		.bat(bat));
	always @(posedge core_clk) if (q.size() > 0)
	begin
		e = q.pop_front();
		`CHK("status", e[6:0], status & e[13:7])
	end
	task end_sim;
		$display("compared %0d mismatches %0d", n_compared, fails);
		if (fails == 0 && n_compared > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask
	// Sample at the falling edge, return on a rising one for the next drive
	task wait_st(input logic [6:0] m, input logic [6:0] v, input int lim);
		for (n = 0; n == 0 || (n < lim && (status & m) !== v); n++)
			@(negedge core_clk);
		q.push_back({m, v});
		@(posedge core_clk);
		if ((status & m) !== v)
			#1 end_sim;
	endtask
	initial
	begin
		repeat (10) @(posedge core_clk);
		reset_n <= 1'b1;
		wait_st(7'h40, 7'h00, 2);
		sd.ac_present <= 1'b1;
		wait_st(7'h60, 7'h60, 4);
		wait_st(7'h46, 7'h06, 9);
		`CHK("pre_time", n >= 3 && n <= 5, 1'b1)
		target <= 8'hd0;
		wait_st(7'h06, 7'h04, 300);
		target <= 8'h80;
		wait_st(7'h54, 7'h50, 99);
		ctrl <= 3'h7;
		repeat (60) @(posedge core_clk);
		ctrl <= 3'h6;
		sd.temp_fault <= 1'b1;
		repeat (30) @(posedge core_clk);
		sd.temp_fault <= 1'b0;
		wait_st(7'h46, 7'h06, 60);
		`CHK("fast_time", n > 30, 1'b1)
		sd.uvlo <= 1'b1;
		wait_st(7'h44, 7'h00, 3);
		sd <= 11'h404;
		iset_ratio <= 8'($random(seed));
		wait_st(7'h41, 7'h41, 6);
		repeat (2) @(posedge core_clk);
		end_sim;
	end
endmodule // tb
`default_nettype wire
